// ---- core/pcsr_bank.sv ----
// command/status configuration register with sticky error flags and interrupt gating
`timescale 1ns/100ps
`include "pcsr_params.svh"
module pcsr_bank #(
  parameter logic HS_CAP   = 1'b0,
  parameter logic CAP_LIST = 1'b0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // configuration access from the bus target
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [3:0]       cfg_be,
  input  wire pcsr_pkg::pcsr_word_t cfg_wdata,
  output pcsr_pkg::pcsr_word_t  cfg_rdata,
  // local preset port
  input  wire logic             preset_wr,
  input  wire pcsr_pkg::pcsr_word_t preset_mask,
  input  wire pcsr_pkg::pcsr_word_t preset_data,
  // error events, master and interrupt status from the bus engines and back end
  input  wire logic             par_err_evt,
  input  wire logic             sys_err_evt,
  input  wire logic             mabt_evt,
  input  wire logic             tabt_rcv_evt,
  input  wire logic             tabt_sig_evt,
  input  wire logic             perr_seen,
  input  wire logic             is_master,
  input  wire logic             int_pending,
  // pins and enables
  output logic                  system_error_pin_oe,
  output logic                  parity_error_pin_oe,
  output logic                  interrupt_a_pin_o,
  output logic                  interrupt_a_pin_oe,
  output logic                  master_allowed,
  output logic                  parity_respond,
  output logic                  mem_space_enable
);
  import pcsr_pkg::*;

  logic       wr_hit;
  logic [3:0] wen;
  logic [5:0] flags;
  logic       interrupt_pin_disable;
  logic       system_error_pin_enable;
  logic       parity_response_enable;
  logic       bus_master_enable;
  logic       mem_sp;
  logic       int_stat;
  logic       drive_serr;
  logic       drive_perr;
  logic [5:0] set_vec;
  logic [5:0] clr_vec;

  assign wr_hit = cfg_wr && (cfg_addr == `PCSR_CFG_OFFSET);
  assign wen    = wr_hit ? cfg_be : 4'h0;

  // error pin drive decisions
  assign drive_serr = sys_err_evt && system_error_pin_enable;
  assign drive_perr = par_err_evt && parity_response_enable;

  // flag set sources, index 5 is bit 31 down to index 1 at bit 27, index 0 bit 24
  assign set_vec[5] = par_err_evt;
  assign set_vec[4] = drive_serr;
  assign set_vec[3] = mabt_evt;
  assign set_vec[2] = tabt_rcv_evt;
  assign set_vec[1] = tabt_sig_evt;
  assign set_vec[0] = (drive_perr || perr_seen) && is_master
                      && parity_response_enable;
  // only a one written into the top byte clears
  assign clr_vec[5:1] = wen[3] ? cfg_wdata[`PCSR_BIT_PAR_DET:`PCSR_BIT_TABT_SIG] : 5'h0;
  assign clr_vec[0]   = wen[3] & cfg_wdata[`PCSR_BIT_MPAR_REP];

  // one sticky cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      pcsr_w1c_flag u_flag (
        .mclk    (mclk),
        .nrst    (nrst),
        .set_evt (set_vec[gi]),
        .clr_req (clr_vec[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  // writable command bits; local preset applies before the bus write in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      interrupt_pin_disable   <= 1'b0;
      system_error_pin_enable <= 1'b0;
      parity_response_enable  <= 1'b0;
      bus_master_enable       <= 1'b0;
      mem_sp                  <= 1'b0;
    end else begin
      if (preset_wr) begin
        if (preset_mask[`PCSR_BIT_INTERRUPT_PIN_DISABLE])  interrupt_pin_disable   <= preset_data[`PCSR_BIT_INTERRUPT_PIN_DISABLE];
        if (preset_mask[`PCSR_BIT_SERR_EN])  system_error_pin_enable <= preset_data[`PCSR_BIT_SERR_EN];
        if (preset_mask[`PCSR_BIT_PAR_RESP]) parity_response_enable  <= preset_data[`PCSR_BIT_PAR_RESP];
        if (preset_mask[`PCSR_BIT_BUS_MST])  bus_master_enable       <= preset_data[`PCSR_BIT_BUS_MST];
        if (preset_mask[`PCSR_BIT_MEM_SP])   mem_sp                  <= preset_data[`PCSR_BIT_MEM_SP];
      end
      if (wen[1]) begin
        interrupt_pin_disable   <= cfg_wdata[`PCSR_BIT_INTERRUPT_PIN_DISABLE];
        system_error_pin_enable <= cfg_wdata[`PCSR_BIT_SERR_EN];
      end
      if (wen[0]) begin
        parity_response_enable <= cfg_wdata[`PCSR_BIT_PAR_RESP];
        bus_master_enable      <= cfg_wdata[`PCSR_BIT_BUS_MST];
        mem_sp                 <= cfg_wdata[`PCSR_BIT_MEM_SP];
      end
    end
  end

  // interrupt status mirrors the back end; same-domain input, no sync
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_stat <= 1'b0;
    end else begin
      int_stat <= int_pending;
    end
  end

  // pin drivers registered so outputs come straight from flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      system_error_pin_oe <= 1'b0;
      parity_error_pin_oe <= 1'b0;
      interrupt_a_pin_o   <= 1'b0;
      interrupt_a_pin_oe  <= 1'b0;
      master_allowed      <= 1'b0;
      parity_respond      <= 1'b0;
      mem_space_enable    <= 1'b0;
    end else begin
      system_error_pin_oe <= drive_serr;
      parity_error_pin_oe <= drive_perr;
      interrupt_a_pin_o   <= 1'b0;                                       // open drain low
      interrupt_a_pin_oe  <= int_pending && !interrupt_pin_disable;
      master_allowed      <= bus_master_enable;
      parity_respond      <= parity_response_enable;
      mem_space_enable    <= mem_sp;
    end
  end

  // read data; hardwired and reserved fields are constants so writes cannot move them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= '0;
    end else if (cfg_rd && (cfg_addr == `PCSR_CFG_OFFSET)) begin
      cfg_rdata                                  <= '0;
      cfg_rdata[`PCSR_BIT_PAR_DET:`PCSR_BIT_TABT_SIG] <= flags[5:1];
      cfg_rdata[`PCSR_SEL_HI:`PCSR_SEL_LO]       <= `PCSR_SEL_VALUE;
      cfg_rdata[`PCSR_BIT_MPAR_REP]              <= flags[0];
      cfg_rdata[`PCSR_BIT_B2B_CAP]               <= 1'b0;
      cfg_rdata[`PCSR_BIT_HS_CAP]                <= HS_CAP;
      cfg_rdata[`PCSR_BIT_CAP_LIST]              <= CAP_LIST;
      cfg_rdata[`PCSR_BIT_INT_STAT]              <= int_stat;
      cfg_rdata[`PCSR_BIT_INTERRUPT_PIN_DISABLE]               <= interrupt_pin_disable;
      cfg_rdata[`PCSR_BIT_SERR_EN]               <= system_error_pin_enable;
      cfg_rdata[`PCSR_BIT_PAR_RESP]              <= parity_response_enable;
      cfg_rdata[`PCSR_BIT_BUS_MST]               <= bus_master_enable;
      cfg_rdata[`PCSR_BIT_MEM_SP]                <= mem_sp;
    end else if (cfg_rd) begin
      cfg_rdata <= '0; // other offsets belong to other registers
    end
  end

  // checks
  property p_serr_flag;
    @(posedge mclk) disable iff (!nrst)
      (sys_err_evt && system_error_pin_enable) |=> flags[4];
  endproperty
  a_serr_flag: assert property (p_serr_flag) else $error("serr flag not set");

  property p_par_flag;
    @(posedge mclk) disable iff (!nrst) par_err_evt |=> flags[5];
  endproperty
  a_par_flag: assert property (p_par_flag) else $error("parity flag not set");

  property p_serr_gate;
    @(posedge mclk) disable iff (!nrst)
      !$past(system_error_pin_enable) |-> !system_error_pin_oe;
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("serr driven while off");

  property p_perr_gate;
    @(posedge mclk) disable iff (!nrst)
      !$past(parity_response_enable) |-> !parity_error_pin_oe;
  endproperty
  a_perr_gate: assert property (p_perr_gate) else $error("perr driven while off");

  property p_int_pin;
    @(posedge mclk) disable iff (!nrst)
      (int_pending && !interrupt_pin_disable) |=> interrupt_a_pin_oe;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin not driven");

  property p_interrupt_pin_disable;
    @(posedge mclk) disable iff (!nrst) interrupt_pin_disable |=> !interrupt_a_pin_oe;
  endproperty
  a_interrupt_pin_disable: assert property (p_interrupt_pin_disable) else $error("interrupt leaked");

  property p_mpar_cond;
    @(posedge mclk) disable iff (!nrst)
      $rose(flags[0]) |-> $past(is_master) && $past(parity_response_enable);
  endproperty
  a_mpar_cond: assert property (p_mpar_cond) else $error("parity reported wrongly");

  property p_w1c_hold;
    @(posedge mclk) disable iff (!nrst)
      (flags[3] && !(wen[3] && cfg_wdata[`PCSR_BIT_MABT_RCV])) |=> flags[3];
  endproperty
  a_w1c_hold: assert property (p_w1c_hold) else $error("flag lost without w1c");

  property p_master_gate;
    @(posedge mclk) disable iff (!nrst) !bus_master_enable |=> !master_allowed;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("master allowed off");
endmodule : pcsr_bank

// ---- core/pcsr_params.svh ----
// constants for the command/status register bank
`ifndef PCSR_PARAMS_SVH
`define PCSR_PARAMS_SVH
`define PCSR_BIT_PAR_DET   31
`define PCSR_BIT_SYS_SIG   30
`define PCSR_BIT_MABT_RCV  29
`define PCSR_BIT_TABT_RCV  28
`define PCSR_BIT_TABT_SIG  27
`define PCSR_SEL_HI        26
`define PCSR_SEL_LO        25
`define PCSR_SEL_VALUE     2'h1
`define PCSR_BIT_MPAR_REP  24
`define PCSR_BIT_B2B_CAP   23
`define PCSR_BIT_HS_CAP    21
`define PCSR_BIT_CAP_LIST  20
`define PCSR_BIT_INT_STAT  19
`define PCSR_BIT_INTERRUPT_PIN_DISABLE   10
`define PCSR_BIT_SERR_EN   8
`define PCSR_BIT_PAR_RESP  6
`define PCSR_BIT_BUS_MST   2
`define PCSR_BIT_MEM_SP    1
`define PCSR_CFG_OFFSET    8'h04
`endif

// ---- core/pcsr_pkg.sv ----
// types for the command/status register bank
package pcsr_pkg;
  typedef logic [31:0] pcsr_word_t;
endpackage : pcsr_pkg

// ---- core/pcsr_w1c_flag.sv ----
// one sticky flag, set by hardware and cleared by writing a one
`timescale 1ns/100ps
module pcsr_w1c_flag (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // set and clear
  input  wire logic set_evt,
  input  wire logic clr_req,
  // state
  output logic      flag
);
  // set wins over a simultaneous clear so no event is lost
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_req) begin
      flag <= 1'b0;
    end
  end
endmodule : pcsr_w1c_flag

// ---- test/pcsr_host_model.sv ----
// host bridge model issuing configuration reads and writes
`timescale 1ns/100ps
module pcsr_host_model (
  // clock
  input  wire logic                 mclk,
  // configuration access
  output logic                      cfg_wr,
  output logic                      cfg_rd,
  output logic [7:0]                cfg_addr,
  output logic [3:0]                cfg_be,
  output pcsr_pkg::pcsr_word_t      cfg_wdata,
  input  wire pcsr_pkg::pcsr_word_t cfg_rdata
);
  import pcsr_pkg::*;
  int gap = 0; // extra idle cycles before each request, for a slow host
  // idle bus after reset
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end
  // one-cycle write strobe, entered and left at a falling edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input pcsr_word_t d);
    // one idle edge first, so a release and the next strobe never share a time step
    repeat (gap + 1) @(negedge mclk);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d; // a one clears a flag
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d; // released bus must not keep its last value
  endtask : cfg_write
  // one-cycle read strobe; data is registered at the taking edge
  task automatic cfg_read(input logic [7:0] a, output pcsr_word_t d);
    // the idle edge also lets level inputs reach the status bits before the read
    repeat (gap + 1) @(negedge mclk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
  endtask : cfg_read
endmodule : pcsr_host_model

// ---- test/tb_top.sv ----
// self-checking bench for the command/status register bank
`timescale 1ns/100ps
module tb_top;
  import pcsr_pkg::*;
  typedef struct {logic [4:0] evt; pcsr_word_t flags;} pcsr_row_t;
  localparam pcsr_word_t BASE = 32'h02300000; // timing 01 plus both capability bits
  localparam pcsr_word_t CMD  = 32'h00000140; // parity response and system error enable
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       cfg_wr, cfg_rd, preset_wr, perr_seen, is_master, int_pending;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [4:0] evt;
  logic       sys_oe, par_oe, int_o, int_oe, mst_ok, par_rsp, mem_en, seen_sys, seen_par;
  pcsr_word_t cfg_wdata, cfg_rdata, preset_mask, preset_data, w;
  int         num_errors = 0;
  int         tests_run = 0;
  // par, sys, master abort, target abort received, target abort signaled
  pcsr_row_t  rows [6] = '{'{5'h10, 32'h80000000}, '{5'h08, 32'h40000000},
    '{5'h04, 32'h20000000}, '{5'h02, 32'h10000000}, '{5'h01, 32'h08000000},
    '{5'h1f, 32'hf8000000}};
  always #2.5 mclk = ~mclk;
  pcsr_host_model host_u (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  pcsr_bank #(.HS_CAP(1'b1), .CAP_LIST(1'b1)) dut_u (.mclk(mclk), .nrst(nrst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .preset_wr(preset_wr),
    .preset_mask(preset_mask), .preset_data(preset_data), .par_err_evt(evt[4]),
    .sys_err_evt(evt[3]), .mabt_evt(evt[2]), .tabt_rcv_evt(evt[1]), .tabt_sig_evt(evt[0]),
    .perr_seen(perr_seen), .is_master(is_master), .int_pending(int_pending),
    .system_error_pin_oe(sys_oe), .parity_error_pin_oe(par_oe), .interrupt_a_pin_o(int_o),
    .interrupt_a_pin_oe(int_oe), .master_allowed(mst_ok), .parity_respond(par_rsp),
    .mem_space_enable(mem_en));
  // masked word compare; an unknown bit matches only an unknown expected bit
  task automatic check_word(input pcsr_word_t got, exp, m, input string what);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, 32'h1, what);
  endtask : check_bit
  task automatic read_chk(input pcsr_word_t exp, m, input string what);
    host_u.cfg_read(8'h04, w);
    check_word(w, exp, m, what);
  endtask : read_chk
  // one-cycle event; pin enables are caught in the following cycle
  task automatic pulse(input logic [4:0] e);
    evt = e;
    @(negedge mclk);
    seen_sys = sys_oe;
    seen_par = par_oe;
    evt = 5'h00;
  endtask : pulse
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // watchdog well beyond the roughly 155 cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_of_test();
  end
  // main sequence, all inputs change at falling edges
  initial begin
    {evt, perr_seen, is_master, int_pending, preset_wr} = '0;
    {preset_mask, preset_data} = '0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    read_chk(BASE, '1, "reset value");
    check_word({25'h0, sys_oe, par_oe, int_o, int_oe, mst_ok, par_rsp, mem_en}, 0, '1, "rst");
    $display("test reset done");
    host_u.cfg_write(8'h04, 4'hf, 32'hffffffff);
    read_chk(BASE | 32'h546, '1, "read-only bits");
    check_word({29'h0, mst_ok, par_rsp, mem_en}, 32'h7, '1, "enables");
    host_u.cfg_read(8'h08, w);
    check_word(w, 32'h0, '1, "unmapped read");
    host_u.cfg_write(8'h04, 4'h3, CMD);
    $display("test write access done");
    foreach (rows[i]) begin
      pulse(rows[i].evt);
      check_bit(seen_sys, rows[i].evt[3], "system error pin");
      check_bit(seen_par, rows[i].evt[4], "parity pin");
      read_chk(BASE | CMD | rows[i].flags, '1, "flag set");
      host_u.cfg_write(8'h04, 4'h8, 32'h0);
      read_chk(BASE | CMD | rows[i].flags, '1, "zero write");
      host_u.cfg_write(8'h04, 4'h8, rows[i].flags);
      read_chk(BASE | CMD, '1, "one clears");
    end
    $display("test event rows done");
    host_u.cfg_write(8'h04, 4'h3, 32'h0);
    pulse(5'h18);
    check_bit(seen_sys, 1'b0, "system error gated");
    check_bit(seen_par, 1'b0, "parity pin gated");
    read_chk(32'h80000000, 32'hc0000000, "parity flag");
    host_u.cfg_write(8'h04, 4'h8, 32'hf9000000);
    $display("test gated pins done");
    host_u.gap = 2;
    for (int k = 0; k < 3; k++) begin
      host_u.cfg_write(8'h04, 4'h1, (k != 2) ? 32'h40 : 32'h0);
      is_master = (k != 1);
      perr_seen = 1'b1;
      @(negedge mclk);
      perr_seen = 1'b0;
      read_chk({7'h0, k == 0, 24'h0}, 32'h01000000, "parity reported");
      host_u.cfg_write(8'h04, 4'h8, 32'h01000000);
      is_master = 1'b0;
    end
    host_u.gap = 0;
    $display("test parity reported done");
    host_u.cfg_write(8'h04, 4'h3, 32'h0);
    int_pending = 1'b1;
    read_chk(32'h80000, 32'h80000, "interrupt status");
    check_bit(int_oe, 1'b1, "interrupt driven");
    check_bit(int_o, 1'b0, "interrupt low");
    host_u.cfg_write(8'h04, 4'h2, 32'h400);
    read_chk(32'h80000, 32'h80000, "status while disabled");
    check_bit(int_oe, 1'b0, "interrupt disabled");
    int_pending = 1'b0;
    host_u.cfg_write(8'h04, 4'h2, 32'h0);
    $display("test interrupt done");
    {preset_mask, preset_data, preset_wr} = {64'hffffffffffffffff, 1'b1};
    @(negedge mclk);
    preset_wr = 1'b0;
    read_chk(BASE | 32'h546, '1, "preset");
    check_bit(mst_ok, 1'b1, "master allowed");
    $display("test preset done");
    nrst = 1'b0;
    @(negedge mclk);
    nrst = 1'b1;
    check_word({29'h0, mst_ok, par_rsp, mem_en}, 32'h0, '1, "mid-run reset");
    read_chk(BASE, '1, "command bits after reset");
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : tb_top
